/* File: hdl/bst_decode.sv */
// Decode and execute of bit set, bit test skip if one, and subroutine call
// Operation
// - Set-bit op forces chosen bit of addressed register to one, flags untouched.
// - Test-skip op with bit zero lets the next instruction run; flags untouched.
// - Test-skip op with bit one discards the already fetched next instruction.
// - A skip inserts a cycle of four idle phases: one cycle plain, two skipped.
`timescale 1ns/1ps
module bst_decode (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [13:0] insn,
  input wire logic [7:0] rf_rdata,
  input wire logic [4:0] pc_high_latch,
  output logic [1:0] phase,
  output logic [6:0] rf_addr,
  output logic rf_rd,
  output logic rf_we,
  output logic [7:0] rf_wdata,
  output logic [12:0] pc,
  output logic stack_push,
  output logic [12:0] stack_data,
  output logic status_we,
  output logic insn_fetch,
  output logic busy_nop
);
  logic cycle_end;
  bst_pkg::bst_state_t state_ff;
  bst_pkg::bst_state_t nxt_state;
  logic [13:0] insn_ff;
  logic [7:0] data_ff;
  logic [12:0] pc_ff;
  logic [12:0] nxt_pc;
  logic [12:0] pc_inc;
  logic [6:0] addr_ff;
  logic rd_ff;
  logic we_ff;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic push_ff;
  logic [12:0] push_data_ff;
  logic exec_ok;
  logic is_set;
  logic is_test;
  logic is_call;
  logic take_skip;
  logic take_call;
  logic [2:0] bit_sel;
  logic [6:0] reg_sel;
  logic [10:0] call_target;
  logic [7:0] bit_mask;
  logic [7:0] sel_hits;
  logic bit_one;

  bst_phase u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // A flushed cycle still holds the discarded word, so every action is gated here
  assign exec_ok = (state_ff == bst_pkg::BST_EXEC);
  assign is_set = (insn_ff[13:10] == bst_pkg::OP_SET_BIT);
  assign is_test = (insn_ff[13:10] == bst_pkg::OP_TEST_SKIP);
  assign is_call = (insn_ff[13:11] == bst_pkg::OP_CALL);
  assign bit_sel = insn_ff[bst_pkg::BIT_MSB:bst_pkg::BIT_LSB];
  assign reg_sel = insn_ff[bst_pkg::ADDR_W-1:0];
  assign call_target = insn_ff[bst_pkg::LIT_W-1:0];
  assign pc_inc = pc_ff + 13'h0001;

  // One-hot mask of the chosen bit and the read bit it picks out
  for (genvar gi = 0; gi < 8; gi++) begin : g_bit
    assign bit_mask[gi] = (bit_sel == 3'(gi));
    assign sel_hits[gi] = data_ff[gi] & bit_mask[gi];
  end

  assign bit_one = |sel_hits;
  assign take_skip = exec_ok && is_test && bit_one;
  assign take_call = exec_ok && is_call;

  // Latch the fetched word at the end of each cycle; flushed cycles ignore it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      insn_ff <= 14'h0000;
    end else if (cycle_end) begin
      insn_ff <= insn;
    end
  end

  // A taken skip and a call both turn the next cycle into four idle phases
  always_comb begin
    nxt_state = bst_pkg::BST_EXEC;
    unique case (state_ff)
      bst_pkg::BST_EXEC: begin
        if (take_skip) begin
          nxt_state = bst_pkg::BST_FLUSH;
        end else if (take_call) begin
          nxt_state = bst_pkg::BST_FLUSH;
        end else begin
          nxt_state = bst_pkg::BST_EXEC;
        end
      end
      bst_pkg::BST_FLUSH: begin
        nxt_state = bst_pkg::BST_EXEC;
      end
      default: begin
        nxt_state = bst_pkg::BST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= bst_pkg::BST_EXEC;
    end else if (cycle_end) begin
      state_ff <= nxt_state;
    end
  end

  // Address goes out at the end of Q1 so the file register answers during Q2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= 7'h00;
    end else if (exec_ok && (is_set || is_test) && phase == bst_pkg::PHASE_Q1) begin
      addr_ff <= reg_sel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ff <= 1'b0;
    end else begin
      rd_ff <= exec_ok && (is_set || is_test) && phase == bst_pkg::PHASE_Q1;
    end
  end

  // Read data is held from the end of Q2 for the test and the write-back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= 8'h00;
    end else if (exec_ok && (is_set || is_test) && phase == bst_pkg::PHASE_Q2) begin
      data_ff <= rf_rdata;
    end
  end

  // Only the chosen bit is forced; the other seven go back as they were read
  always_comb begin
    nxt_wdata = data_ff | bit_mask;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_ff <= 1'b0;
    end else begin
      we_ff <= exec_ok && is_set && phase == bst_pkg::PHASE_Q3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_ff <= 8'h00;
    end else if (exec_ok && is_set && phase == bst_pkg::PHASE_Q3) begin
      wdata_ff <= nxt_wdata;
    end
  end

  // Return address goes to the stack in Q2 of the call's first cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      push_ff <= 1'b0;
    end else begin
      push_ff <= take_call && phase == bst_pkg::PHASE_Q1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      push_data_ff <= 13'h0000;
    end else if (take_call && phase == bst_pkg::PHASE_Q1) begin
      push_data_ff <= pc_inc;
    end
  end

  // Upper bits come from the latch, so a call can leave the current page.
  // A flushed cycle still steps by one, which walks past the discarded word.
  always_comb begin
    nxt_pc = pc_inc;
    if (take_call) begin
      nxt_pc = {pc_high_latch[4:3], call_target};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= bst_pkg::PC_RESET;
    end else if (cycle_end) begin
      pc_ff <= nxt_pc;
    end
  end

  assign rf_addr = addr_ff;
  assign rf_rd = rd_ff;
  assign rf_we = we_ff;
  assign rf_wdata = wdata_ff;
  assign pc = pc_ff;
  assign stack_push = push_ff;
  assign stack_data = push_data_ff;
  // None of these operations touches the status flags
  assign status_we = 1'b0;
  assign insn_fetch = cycle_end;
  assign busy_nop = (state_ff == bst_pkg::BST_FLUSH);
endmodule

/* File: hdl/bst_phase.sv */
// Four-phase sequencer splitting each instruction cycle into Q1..Q4
`timescale 1ns/1ps
module bst_phase (
  input wire logic clk,
  input wire logic rst_n,
  output logic [1:0] phase,
  output logic cycle_end
);
  logic [1:0] phase_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= bst_pkg::PHASE_Q1;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  assign phase = phase_ff;
  assign cycle_end = (phase_ff == bst_pkg::PHASE_Q4);
endmodule

/* File: hdl/bst_pkg.sv */
// Constants for the bit set, bit test skip and call decode block
package bst_pkg;
  localparam int INSN_W = 14;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam int BIT_MSB = 9;
  localparam int BIT_LSB = 7;
  localparam logic [3:0] OP_SET_BIT = 4'h5;
  localparam logic [3:0] OP_TEST_SKIP = 4'h7;
  localparam logic [2:0] OP_CALL = 3'h4;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q3 = 2'h2;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  typedef enum logic [1:0] {
    BST_EXEC = 2'b00,
    BST_FLUSH = 2'b01
  } bst_state_t;
endpackage

/* File: tb/bst_chk.sv */
// Checker for the decode block
`timescale 1ns/1ps
module bst_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rf_rd,
  input wire logic rf_we,
  input wire logic stack_push,
  input wire logic [12:0] stack_data,
  input wire logic [12:0] pc,
  input wire logic status_we,
  input wire logic busy_nop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wr; rf_we |-> $past(rf_rd, 2); endproperty
  a_wr: assert property (p_wr) else $error("write without read");
  property p_flag; rf_rd |-> ##[0:3] !status_we; endproperty
  a_flag: assert property (p_flag) else $error("flags written");
  property p_quiet; busy_nop |-> !rf_rd && !rf_we && !stack_push; endproperty
  a_quiet: assert property (p_quiet) else $error("work in no-op");
  property p_nop; $rose(busy_nop) |-> busy_nop [*4] ##1 !busy_nop; endproperty
  a_nop: assert property (p_nop) else $error("no-op length");
  property p_push; stack_push |-> stack_data == pc + 13'h0001; endproperty
  a_push: assert property (p_push) else $error("pushed value");
  property p_call; stack_push |-> ##[2:5] busy_nop; endproperty
  a_call: assert property (p_call) else $error("call no-op");
  cover property (rf_we);
  cover property ($rose(busy_nop));
  cover property (stack_push);
endmodule
bind bst_decode bst_chk i_bst_chk (.clk, .rst_n, .rf_rd, .rf_we, .stack_push, .stack_data,
  .pc, .status_we, .busy_nop);

/* File: tb/testbench.sv */
// Directed bench for the decode block
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] set_op = bst_pkg::OP_SET_BIT;
  localparam logic [3:0] tst_op = bst_pkg::OP_TEST_SKIP;
  logic clk = 0;
  logic rst_n = 0;
  logic [13:0] insn = '0;
  logic [7:0] rf_rdata = '0;
  logic [4:0] pc_high_latch = 5'h18;
  logic [1:0] phase;
  logic rf_we, stack_push, busy_nop;
  logic rf_rd, status_we, insn_fetch;
  logic [6:0] rf_addr;
  logic [6:0] ad_s[3];
  logic [3:0] fe_s[3];
  logic st_s = 0;
  logic [7:0] rf_wdata;
  logic [12:0] pc, stack_data;
  logic we_s[3], nop_s[3];
  logic [7:0] wd_s[3];
  logic [12:0] pc_s[3], sd_s[3];
  int err_total = 0;
  int n_compared = 0;
  bst_decode i_bst_decode (.clk, .rst_n, .insn, .rf_rdata, .pc_high_latch, .phase,
    .rf_addr, .rf_rd, .rf_we, .rf_wdata, .pc, .stack_push, .stack_data,
    .status_we, .insn_fetch, .busy_nop);
  initial forever #50 clk = ~clk;
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [12:0] got, logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Feeds two words back to back, then a zero word, and records three cycles
  task automatic run(logic [13:0] w1, logic [13:0] w2, logic [7:0] r1, logic [7:0] r2);
    int n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (phase !== 2'h2 && n < 20);
    if (n == 20) chk("phase wait", 13'h0000, 13'h0001);
    if (n == 20) summarize();
    @(posedge clk);
    insn <= w1;
    rf_rdata <= r1;
    for (int k = 0; k < 3; k++) begin
      we_s[k] = 0;
      nop_s[k] = 0;
      wd_s[k] = 8'h00;
      fe_s[k] = 4'h0;
      for (int j = 0; j < 4; j++) begin
        @(posedge clk);
        if (j == 3) insn <= k ? 14'h0000 : w2;
        if (j == 3) rf_rdata <= k ? 8'h00 : r2;
        #1;
        if (j == 0) pc_s[k] = pc;
        if (rf_rd === 1'b1) ad_s[k] = rf_addr;
        st_s |= status_we;
        fe_s[k] = {fe_s[k][2:0], insn_fetch};
        if (rf_we === 1'b1) {we_s[k], wd_s[k]} = {1'b1, rf_wdata};
        if (stack_push === 1'b1) sd_s[k] = stack_data;
        nop_s[k] |= busy_nop;
      end
    end
  endtask
  task automatic t_set;
    run({set_op, 3'h7, 7'h15}, {set_op, 3'h0, 7'h7f}, 8'h0a, 8'hfe);
    chk("set data", wd_s[0], 8'h8a);
    chk("set data2", wd_s[1], 8'hff);
    chk("set addr", ad_s[0], 7'h15);
    chk("set flags", st_s, 1'h0);
    chk("fetch strobe", fe_s[0], 4'h1);
  endtask
  task automatic t_skip;
    run({tst_op, 3'h1, 7'h20}, {set_op, 3'h2, 7'h21}, 8'h02, 8'h00);
    chk("skip discard", we_s[1], 1'h0);
    chk("skip nop", nop_s[1], 1'h1);
  endtask
  task automatic t_noskip;
    run({tst_op, 3'h1, 7'h20}, {set_op, 3'h3, 7'h22}, 8'hfd, 8'h00);
    chk("noskip nop", nop_s[1], 1'h0);
    chk("noskip data", wd_s[1], 8'h08);
    chk("test addr", ad_s[0], 7'h20);
    chk("test flags", st_s, 1'h0);
  endtask
  // Mid-run reset, so the call below starts from a known program counter
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    #1;
    chk("reset pc", pc, 13'h0000);
    chk("reset nop", busy_nop, 1'h0);
    chk("reset phase", phase, 2'h0);
  endtask
  task automatic t_call;
    run({bst_pkg::OP_CALL, 11'h2a5}, 14'h0000, 8'h00, 8'h00);
    chk("call pc0", pc_s[0], 13'h0001);
    chk("push data", sd_s[0], 13'h0002);
    chk("call pc", pc_s[1], 13'h1aa5);
    chk("call nop", nop_s[1], 1'h1);
    chk("call step", pc_s[2], 13'h1aa6);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_set();
    t_skip();
    t_noskip();
    t_reset();
    t_call();
    summarize();
  end
endmodule
